// *** rtl/pcc_defines.vh ***
// offsets, field positions and reset values of the config command/class registers
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
`define PCC_OFS_CMD_STATUS      8'h04
`define PCC_OFS_CLASS_REV       8'h08
`define PCC_BIT_PARITY_FLAG     31
`define PCC_BIT_SYS_ERR_STATUS  30
`define PCC_BIT_NEW_CAP         20
`define PCC_BIT_SYS_ERR_RESP_EN 8
`define PCC_BIT_PARITY_RESP_EN  6
`define PCC_BIT_BUS_MASTER_EN   2
`define PCC_BIT_MEM_SPACE_EN    1
`define PCC_BIT_IO_SPACE_CTRL   0
`define PCC_PM_NEW_CAP_BIT      19
`define PCC_RST_SYS_ERR_RESP_EN 1'h1
`define PCC_RST_PARITY_RESP_EN  1'h0
`define PCC_RST_BUS_MASTER_EN   1'h1
`define PCC_RST_MEM_SPACE_EN    1'h1
`define PCC_RST_IO_SPACE_CTRL   1'h1
`define PCC_BASE_CLASS          8'h02
`define PCC_SUB_CLASS           8'h00
`endif

// *** rtl/pcc_config_command_class.v ***
// config command/status register (both halves) and class-code/revision register
`timescale 1ns/1ps
`include "pcc_defines.vh"

// Notes on behaviour
// - status bit 20 reads back bit 19 of the power management control register.
// - with system-error response enabled (bit 8, reset 1) an address parity error asserts the system error pin.
// - with parity-error response disabled (bit 6, reset 0) detected parity errors do not drive the status control system error output.
// - with parity-error response enabled a detected parity error raises bit 13 of the status control register.
// - bus-master enable at bit 2, read/write, reset 1, allows master transactions when 1.
// - memory-space enable at bit 1, read/write, reset 1, permits memory accesses when 1.
// - io space control at bit 0, reset 1, enables io access when 0 and disables it when 1.
// - class bits 31 to 24 read 02h and ignore writes.
// - class bits 23 to 16 read subclass 00h and ignore writes.
// - class bits 7 to 4 hold a fixed revision, bits 15 to 8 are reserved.
// - parity error flag at bit 31 sets on any parity error, whatever the response enable.
module pcc_config_command_class #(
    parameter [3:0] SILICON_REVISION = 4'h1 // arbitrary value
) (
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_cfg_wr,
    input  wire        i_cfg_rd,
    input  wire [7:0]  i_cfg_addr,
    input  wire [3:0]  i_cfg_be,
    input  wire [31:0] i_cfg_wdata,
    output reg  [31:0] o_cfg_rdata,
    input  wire [31:0] i_power_mgmt_control_reg,
    input  wire        i_addr_parity_err,
    input  wire        i_data_parity_err,
    output wire        o_serr_n,
    output wire        o_status_control_sys_err,
    output wire        o_bus_master_en,
    output wire        o_mem_space_en,
    output wire        o_io_space_en
);

    reg         sys_error_resp_en_r;
    reg         parity_resp_en_r;
    reg         bus_master_en_r;
    reg         mem_space_en_r;
    reg         io_space_ctrl_r;
    reg         parity_error_flag_r;
    reg         sys_err_status_r;
    reg         serr_r;
    reg         sys_err_ind_r;
    wire        any_parity_err;
    wire        serr_event;
    wire        wr_cmd;
    wire [31:0] cmd_rd;
    wire [31:0] class_rd;

    assign any_parity_err = i_addr_parity_err | i_data_parity_err;
    assign serr_event     = sys_error_resp_en_r & i_addr_parity_err;
    assign wr_cmd         = i_cfg_wr && (i_cfg_addr == `PCC_OFS_CMD_STATUS);

    // command bits live in byte lanes 0 and 1
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            sys_error_resp_en_r <= `PCC_RST_SYS_ERR_RESP_EN;
            parity_resp_en_r    <= `PCC_RST_PARITY_RESP_EN;
            bus_master_en_r     <= `PCC_RST_BUS_MASTER_EN;
            mem_space_en_r      <= `PCC_RST_MEM_SPACE_EN;
            io_space_ctrl_r     <= `PCC_RST_IO_SPACE_CTRL;
        end else if (wr_cmd) begin
            if (i_cfg_be[1]) begin
                sys_error_resp_en_r <= i_cfg_wdata[`PCC_BIT_SYS_ERR_RESP_EN];
            end
            if (i_cfg_be[0]) begin
                parity_resp_en_r <= i_cfg_wdata[`PCC_BIT_PARITY_RESP_EN];
                bus_master_en_r  <= i_cfg_wdata[`PCC_BIT_BUS_MASTER_EN];
                mem_space_en_r   <= i_cfg_wdata[`PCC_BIT_MEM_SPACE_EN];
                io_space_ctrl_r  <= i_cfg_wdata[`PCC_BIT_IO_SPACE_CTRL];
            end
        end
    end

    // status flags clear by writing 1; a new event wins over the clear
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            parity_error_flag_r <= 1'b0;
            sys_err_status_r    <= 1'b0;
        end else begin
            if (any_parity_err) begin
                parity_error_flag_r <= 1'b1;
            end else if (wr_cmd && i_cfg_be[3] && i_cfg_wdata[`PCC_BIT_PARITY_FLAG]) begin
                parity_error_flag_r <= 1'b0;
            end
            if (serr_event) begin
                sys_err_status_r <= 1'b1;
            end else if (wr_cmd && i_cfg_be[3] && i_cfg_wdata[`PCC_BIT_SYS_ERR_STATUS]) begin
                sys_err_status_r <= 1'b0;
            end
        end
    end

    // outputs follow the error inputs one cycle later, registered to keep pins glitch free
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            serr_r        <= 1'b0;
            sys_err_ind_r <= 1'b0;
        end else begin
            serr_r        <= serr_event;
            sys_err_ind_r <= parity_resp_en_r & any_parity_err;
        end
    end

    assign o_serr_n                 = ~serr_r;
    assign o_status_control_sys_err = sys_err_ind_r;
    assign o_bus_master_en          = bus_master_en_r;
    assign o_mem_space_en           = mem_space_en_r;
    assign o_io_space_en            = ~io_space_ctrl_r;

    assign cmd_rd = {parity_error_flag_r, sys_err_status_r, 9'h000,
                     i_power_mgmt_control_reg[`PCC_PM_NEW_CAP_BIT],
                     11'h000, sys_error_resp_en_r, 1'b0, parity_resp_en_r,
                     3'h0, bus_master_en_r, mem_space_en_r, io_space_ctrl_r};
    assign class_rd = {`PCC_BASE_CLASS, `PCC_SUB_CLASS, 8'h00, SILICON_REVISION, 4'h0};

    // read data registered; unmapped offsets read zero
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_cfg_rdata <= 32'h00000000;
        end else if (i_cfg_rd) begin
            case (i_cfg_addr)
                `PCC_OFS_CMD_STATUS: o_cfg_rdata <= cmd_rd;
                `PCC_OFS_CLASS_REV:  o_cfg_rdata <= class_rd;
                default:             o_cfg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// *** tb/pcc_asserts.sv ***
// port assertions for the config command/class block
`timescale 1ns/1ps
module pcc_asserts #(parameter [3:0] REV = 4'h1) (
    input wire i_core_clk, i_rst, i_cfg_wr, i_cfg_rd, i_addr_parity_err, i_data_parity_err,
    input wire [7:0] i_cfg_addr, input wire [3:0] i_cfg_be, input wire [31:0] i_cfg_wdata, o_cfg_rdata,
    input wire [31:0] i_power_mgmt_control_reg,
    input wire o_serr_n, o_status_control_sys_err, o_bus_master_en, o_mem_space_en, o_io_space_en);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire rd4 = i_cfg_rd && i_cfg_addr == 8'h04;
    wire rd8 = i_cfg_rd && i_cfg_addr == 8'h08;
    wire wr4 = i_cfg_wr && i_cfg_addr == 8'h04 && i_cfg_be[0];
    property p_serr; !o_serr_n |-> $past(i_addr_parity_err); endproperty
    a_serr: assert property (p_serr) else $error("stray serr");
    property p_sys; o_status_control_sys_err |-> $past(i_addr_parity_err) || $past(i_data_parity_err); endproperty
    a_sys: assert property (p_sys) else $error("stray sys err");
    property p_cls; rd8 |=> o_cfg_rdata[31:8] == 24'h020000; endproperty
    a_cls: assert property (p_cls) else $error("bad class");
    property p_rev; rd8 |=> o_cfg_rdata[7:4] == REV; endproperty
    a_rev: assert property (p_rev) else $error("bad revision");
    property p_cap; rd4 |=> o_cfg_rdata[20] == $past(i_power_mgmt_control_reg[19]); endproperty
    a_cap: assert property (p_cap) else $error("bad new cap");
    property p_en; wr4 |=> o_bus_master_en == $past(i_cfg_wdata[2]) && o_mem_space_en == $past(i_cfg_wdata[1]); endproperty
    a_en: assert property (p_en) else $error("bad enables");
    property p_io; wr4 |=> o_io_space_en != $past(i_cfg_wdata[0]); endproperty
    a_io: assert property (p_io) else $error("bad io enable");
    property p_flag; i_data_parity_err ##1 (rd4 && !i_cfg_wr) |=> o_cfg_rdata[31]; endproperty
    a_flag: assert property (p_flag) else $error("parity flag lost");
    c_wr: cover property (wr4);
    c_rd: cover property (rd8);
    c_serr: cover property (!o_serr_n);
endmodule

// *** tb/pcc_host.sv ***
// host model issuing config writes and reads
`timescale 1ns/1ps
module pcc_host (input wire i_core_clk, output reg o_wr, o_rd, output reg [7:0] o_addr,
    output reg [3:0] o_be, output reg [31:0] o_wdata);
    logic [63:0] exq[$];
    initial {o_wr, o_rd, o_addr, o_be, o_wdata} = '0;
    task cyc(input w, input [7:0] a, input [3:0] b, input [31:0] d);
        @(posedge i_core_clk) #1 {o_wr, o_rd, o_addr, o_be, o_wdata} = {w, !w, a, b, d};
        @(posedge i_core_clk) #1 {o_wr, o_rd} = 2'b00;
        o_wdata = ~d; // released bus never shows stale data
    endtask
    task rd(input [7:0] a, input [31:0] m, input [31:0] e);
        exq.push_back({m, e});
        cyc(1'b0, a, 4'h0, 32'h0);
    endtask
endmodule

// *** tb/pcc_config_command_class_bench.sv ***
// self-checking bench for the config command/class block
`timescale 1ns/1ps
module pcc_config_command_class_bench;
    logic i_core_clk = 0, i_rst = 1, ape = 0, dpe = 0;
    logic [31:0] pm = 0, r;
    logic [63:0] m;
    wire wr, rd, serr_n, sys_err, bm, mem, io;
    wire [7:0] addr;
    wire [3:0] be;
    wire [31:0] wd, rdata;
    int seed = 32'h6da2869a, mismatches = 0, comparisons = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    pcc_host h(.i_core_clk(i_core_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_be(be), .o_wdata(wd));
    pcc_config_command_class dut(.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg_wr(wr), .i_cfg_rd(rd),
        .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdata), .i_power_mgmt_control_reg(pm),
        .i_addr_parity_err(ape), .i_data_parity_err(dpe), .o_serr_n(serr_n), .o_status_control_sys_err(sys_err),
        .o_bus_master_en(bm), .o_mem_space_en(mem), .o_io_space_en(io));
    task chk(input [31:0] g, input [31:0] e);
        comparisons++;
        if (g !== e) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, g, e); end
    endtask
    task pe(input a, input d, input [1:0] e);
        @(posedge i_core_clk) #1 {ape, dpe} = {a, d};
        @(posedge i_core_clk) #1 {ape, dpe} = 2'b00;
        chk({serr_n, sys_err}, e);
    endtask
    task test_done;
        $display("compared %0d, mismatched %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge i_core_clk) if (rd === 1'b1) begin
        #2 m = h.exq.pop_front();
        chk(rdata & m[63:32], m[31:0]);
    end
    initial begin
        repeat (2) @(posedge i_core_clk);
        #1 i_rst = 0;
        chk({bm, mem, io}, 3'b110);
        h.rd(8'h04, 32'h0000_0147, 32'h0000_0107);
        h.rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
        h.rd(8'h08, 32'hFFFF_FFFF, 32'h0200_0010);
        $display("reset values done");
        repeat (4) begin
            r = $random(seed);
            pm = $random(seed);
            h.cyc(1'b1, 8'h08, 4'hF, r);
            h.cyc(1'b1, 8'h04, 4'hF, r);
            chk({bm, mem, io}, {r[2:1], ~r[0]});
            h.rd(8'h04, 32'hFFFF_FFFF, (r & 32'h147) | {11'h0, pm[19], 20'h0});
            h.rd(8'h08, 32'hFFFF_FFFF, 32'h0200_0010);
        end
        $display("random writes done");
        h.cyc(1'b1, 8'h04, 4'hF, 32'h0000_0100);
        pe(1'b0, 1'b1, 2'b10);
        pe(1'b1, 1'b0, 2'b00);
        h.rd(8'h04, 32'hC000_0000, 32'hC000_0000);
        h.cyc(1'b1, 8'h04, 4'hF, 32'hC000_0040);
        pe(1'b1, 1'b1, 2'b11);
        h.rd(8'h04, 32'hC000_0000, 32'h8000_0000);
        h.cyc(1'b1, 8'h04, 4'h8, 32'h8000_0000);
        @(posedge i_core_clk) #1 dpe = 1'b1;
        fork
            h.rd(8'h04, 32'h8000_0000, 32'h8000_0000);
            begin
                @(posedge i_core_clk) #1 dpe = 1'b0;
            end
        join
        @(posedge i_core_clk) #1 i_rst = 1;
        @(posedge i_core_clk) #1 i_rst = 0;
        chk({bm, mem, io}, 3'b110);
        chk(rdata, 32'h0000_0000);
        chk({serr_n, sys_err}, 2'b10);
        $display("parity and reset done");
        repeat (4) if (h.exq.size() != 0) @(posedge i_core_clk);
        if (h.exq.size() != 0) mismatches++;
        test_done;
    end
endmodule
bind pcc_config_command_class pcc_asserts #(.REV(SILICON_REVISION)) u_chk(.*);
